// ==== i2c_master_write_sequencer.sv ====
// I2C master write sequencer: command list, transmit RAM, bit engine
`timescale 1ns/100ps
`include "i2c_wr_defines.svh"
module i2c_master_write_sequencer (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic master_select,
  input wire logic nonfifo_en,
  input wire logic config_sync_strobe,
  input wire logic transfer_go,
  input wire logic [`CMD_W-1:0] cmd_entry_0,
  input wire logic [`CMD_W-1:0] cmd_entry_1,
  input wire logic [`CMD_W-1:0] cmd_entry_2,
  input wire logic tx_wr_en,
  input wire logic [`RAM_AW-1:0] tx_wr_addr,
  input wire logic [`BYTE_W-1:0] tx_wr_data,
  input wire logic [`RAM_AW-1:0] rx_rd_addr,
  output logic [`BYTE_W-1:0] rx_rd_data,
  input wire logic irq_clr_done,
  input wire logic irq_clr_nack,
  output logic xfer_done_irq,
  output logic ack_mismatch_irq,
  output logic busy,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    i2c_wr_pkg::seq_state_t st;
    logic [7:0] tmr;
    logic [1:0] cmd_idx;
    logic [2:0][`CMD_W-1:0] cmds;
    logic ms;
    logic nonfifo;
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic scl_oe;
    logic sda_oe;
    logic pin_lo;
    logic [7:0] shift;
    logic [2:0] bit_cnt;
    logic [7:0] byte_rem;
    logic [7:0] fetch_rem;
    logic [`RAM_AW-1:0] rd_ptr;
    logic [`RAM_AW-1:0] wr_ptr;
    logic [`RAM_AW-1:0] rx_ptr;
    logic [7:0] rb;
    logic [7:0] rx_rd;
    logic first_start;
    logic nacked;
    logic done_irq;
    logic nack_irq;
    logic busy;
  } seq_t;

  localparam logic [7:0] HALF_LAST = 8'(`SCL_HALF_CYC - 1);
  localparam logic [7:0] QTR = 8'(`SCL_QTR_CYC);

  seq_t s_q;
  seq_t s_d;
  logic [`BYTE_W-1:0] tx_ram [`RAM_DEPTH];
  logic [`BYTE_W-1:0] rx_ram [`RAM_DEPTH];
  logic [`CMD_W-1:0] cur;
  logic [2:0] opc;
  logic hi_phase;
  logic counting;
  logic half_done;
  logic push_valid;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic [7:0] pop_data;
  logic fifo_flush;
  logic rx_we;
  logic mismatch;

  assign cur = (s_q.cmd_idx == 2'd3) ? {`OPC_STOP, 11'h000} : s_q.cmds[s_q.cmd_idx];
  assign opc = cur[`CMD_OPC_HI:`CMD_OPC_LO];
  assign hi_phase = (s_q.st == i2c_wr_pkg::ST_RS_HI) || (s_q.st == i2c_wr_pkg::ST_BIT_HI) ||
                    (s_q.st == i2c_wr_pkg::ST_ACK_HI) || (s_q.st == i2c_wr_pkg::ST_SP_HI);
  // High phases start timing only once SCL is seen high, so slave stretching is honoured
  assign counting = hi_phase ? s_q.scl_s : 1'b1;
  assign half_done = counting && (s_q.tmr == HALF_LAST);
  assign push_valid = (s_q.fetch_rem != 8'h00);
  assign pop_ready = (s_q.st == i2c_wr_pkg::ST_LOAD);
  assign mismatch = cur[`CMD_ACK_CHK] && (s_q.sda_s != cur[`CMD_ACK_EXP]);

  tx_byte_fifo #(
    .W(`BYTE_W),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .flush(fifo_flush),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(tx_ram[s_q.rd_ptr]),
    .out_valid(pop_valid),
    .out_ready(pop_ready),
    .out_data(pop_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    fifo_flush = 1'b0;
    rx_we = 1'b0;
    s_d.scl_m = scl_in;
    s_d.scl_s = s_q.scl_m;
    s_d.sda_m = sda_in;
    s_d.sda_s = s_q.sda_m;
    s_d.rx_rd = rx_ram[rx_rd_addr];
    if (counting) begin
      s_d.tmr = s_q.tmr + 8'h01;
    end
    if (config_sync_strobe && !s_q.busy) begin
      s_d.ms = master_select;
      s_d.nonfifo = nonfifo_en;
      s_d.cmds = {cmd_entry_2, cmd_entry_1, cmd_entry_0};
    end
    if (tx_wr_en && !s_q.nonfifo) begin
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (push_valid && push_ready) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
      s_d.fetch_rem = s_q.fetch_rem - 8'h01;
    end
    case (s_q.st)
      i2c_wr_pkg::ST_IDLE: begin
        if (transfer_go && s_q.ms) begin
          s_d.st = i2c_wr_pkg::ST_WAIT_SCL;
          s_d.busy = 1'b1;
          s_d.cmd_idx = 2'd0;
          s_d.first_start = 1'b1;
          s_d.nacked = 1'b0;
          s_d.rx_ptr = '0;
          s_d.fetch_rem = 8'h00;
          fifo_flush = 1'b1;
          if (s_q.nonfifo) begin
            s_d.rd_ptr = '0;
          end
        end
      end
      i2c_wr_pkg::ST_WAIT_SCL: begin
        if (s_q.scl_s) begin
          s_d.st = i2c_wr_pkg::ST_CMD;
        end
      end
      i2c_wr_pkg::ST_CMD: begin
        case (opc)
          `OPC_RESTART: begin
            s_d.st = s_q.first_start ? i2c_wr_pkg::ST_RS_HI : i2c_wr_pkg::ST_RS_LO;
          end
          `OPC_WRITE: begin
            if (cur[`CMD_BNUM_HI:`CMD_BNUM_LO] == 8'h00) begin
              s_d.cmd_idx = s_q.cmd_idx + 2'd1;
            end else begin
              s_d.st = i2c_wr_pkg::ST_LOAD;
              s_d.byte_rem = cur[`CMD_BNUM_HI:`CMD_BNUM_LO];
              s_d.fetch_rem = cur[`CMD_BNUM_HI:`CMD_BNUM_LO];
            end
          end
          `OPC_STOP: begin
            s_d.st = i2c_wr_pkg::ST_SP_LO;
          end
          default: begin
            // Unsupported opcodes end the sequence without touching the bus
            s_d.st = i2c_wr_pkg::ST_IDLE;
            s_d.busy = 1'b0;
          end
        endcase
      end
      i2c_wr_pkg::ST_RS_LO: begin
        if (s_q.tmr == QTR) begin
          s_d.sda_oe = 1'b0;
        end
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_RS_HI;
          s_d.scl_oe = 1'b0;
        end
      end
      i2c_wr_pkg::ST_RS_HI: begin
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_RS_SDA;
          s_d.sda_oe = 1'b1;
        end
      end
      i2c_wr_pkg::ST_RS_SDA: begin
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_CMD;
          s_d.scl_oe = 1'b1;
          s_d.first_start = 1'b0;
          s_d.cmd_idx = s_q.cmd_idx + 2'd1;
        end
      end
      i2c_wr_pkg::ST_LOAD: begin
        if (pop_valid) begin
          s_d.st = i2c_wr_pkg::ST_BIT_LO;
          s_d.shift = pop_data;
          s_d.bit_cnt = 3'd7;
          s_d.scl_oe = 1'b1;
        end
      end
      i2c_wr_pkg::ST_BIT_LO: begin
        if (s_q.tmr == QTR) begin
          s_d.sda_oe = ~s_q.shift[7];
        end
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_BIT_HI;
          s_d.scl_oe = 1'b0;
        end
      end
      i2c_wr_pkg::ST_BIT_HI: begin
        if (half_done) begin
          s_d.scl_oe = 1'b1;
          s_d.rb = {s_q.rb[6:0], s_q.sda_s};
          s_d.shift = {s_q.shift[6:0], 1'b0};
          s_d.bit_cnt = s_q.bit_cnt - 3'd1;
          s_d.st = (s_q.bit_cnt == 3'd0) ? i2c_wr_pkg::ST_ACK_LO : i2c_wr_pkg::ST_BIT_LO;
        end
      end
      i2c_wr_pkg::ST_ACK_LO: begin
        if (s_q.tmr == QTR) begin
          s_d.sda_oe = 1'b0;
        end
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_ACK_HI;
          s_d.scl_oe = 1'b0;
        end
      end
      i2c_wr_pkg::ST_ACK_HI: begin
        if (half_done) begin
          s_d.scl_oe = 1'b1;
          rx_we = 1'b1;
          s_d.rx_ptr = s_q.rx_ptr + 1'b1;
          s_d.byte_rem = s_q.byte_rem - 8'h01;
          if (mismatch) begin
            s_d.st = i2c_wr_pkg::ST_SP_LO;
            s_d.nacked = 1'b1;
            s_d.fetch_rem = 8'h00;
            fifo_flush = 1'b1;
          end else if (s_q.byte_rem == 8'h01) begin
            s_d.st = i2c_wr_pkg::ST_CMD;
            s_d.cmd_idx = s_q.cmd_idx + 2'd1;
          end else begin
            s_d.st = i2c_wr_pkg::ST_LOAD;
          end
        end
      end
      i2c_wr_pkg::ST_SP_LO: begin
        s_d.scl_oe = 1'b1;
        if (s_q.tmr == QTR) begin
          s_d.sda_oe = 1'b1;
        end
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_SP_HI;
          s_d.scl_oe = 1'b0;
        end
      end
      i2c_wr_pkg::ST_SP_HI: begin
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_SP_END;
          s_d.sda_oe = 1'b0;
        end
      end
      i2c_wr_pkg::ST_SP_END: begin
        if (half_done) begin
          s_d.st = i2c_wr_pkg::ST_IDLE;
          s_d.busy = 1'b0;
        end
      end
      default: begin
        s_d.st = i2c_wr_pkg::ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
    if (s_d.st != s_q.st) begin
      s_d.tmr = 8'h00;
    end
    // Set wins over a clear in the same cycle
    if (irq_clr_done) begin
      s_d.done_irq = 1'b0;
    end
    if (irq_clr_nack) begin
      s_d.nack_irq = 1'b0;
    end
    if (s_q.st == i2c_wr_pkg::ST_SP_END && half_done && !s_q.nacked) begin
      s_d.done_irq = 1'b1;
    end
    if (s_q.st == i2c_wr_pkg::ST_ACK_HI && half_done && mismatch) begin
      s_d.nack_irq = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers and memories
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && tx_wr_en) begin
      tx_ram[s_q.nonfifo ? tx_wr_addr : s_q.wr_ptr] <= tx_wr_data;
    end
    if (clk_en && rx_we) begin
      rx_ram[s_q.rx_ptr] <= s_q.rb;
    end
  end

  assign scl_oe = s_q.scl_oe;
  assign sda_oe = s_q.sda_oe;
  assign scl_out = s_q.pin_lo;
  assign sda_out = s_q.pin_lo;
  assign xfer_done_irq = s_q.done_irq;
  assign ack_mismatch_irq = s_q.nack_irq;
  assign busy = s_q.busy;
  assign rx_rd_data = s_q.rx_rd;

endmodule

// ==== i2c_slave_model.sv ====
// Behavioural write slave: reports each byte, acknowledges each one except byte nack_at and a read address byte
`timescale 1ns/100ps
module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [4:0] nack_at,
  output logic sda_pull,
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  int bitn = 0;
  int idx = 0;
  logic [7:0] sh = 8'h00;
  initial begin
    sda_pull = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end
  // Start condition restarts byte framing
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      bitn = 0;
      idx = 0;
    end
  end
  always @(posedge scl) begin
    if (bitn < 8) begin
      sh = {sh[6:0], sda};
      bitn++;
    end
  end
  always @(negedge scl) begin
    if (bitn == 8) begin
      rx_byte = sh;
      rx_stb = 1'b1;
      // Refuses a read direction bit in the address byte
      sda_pull = (idx != int'(nack_at)) && !(idx == 0 && sh[0]);
      bitn = 9;
      #1 rx_stb = 1'b0;
    end else if (bitn == 9) begin
      sda_pull = 1'b0;
      bitn = 0;
      idx++;
    end
  end
endmodule

// ==== i2c_wr_checker.sv ====
// Port-level checks of the write sequencer
`timescale 1ns/100ps
module i2c_wr_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic transfer_go,
  input wire logic irq_clr_done,
  input wire logic irq_clr_nack,
  input wire logic xfer_done_irq,
  input wire logic ack_mismatch_irq,
  input wire logic busy,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic [7:0] lo_cnt_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lo_cnt_q <= 8'h00;
    end else begin
      lo_cnt_q <= scl_oe ? lo_cnt_q + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_open_drain: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_busy_go: assert property ($rose(busy) |-> $past(transfer_go) && !sda_oe ##1 !sda_oe)
    else $error("busy without go or early drive");
  a_start_scl: assert property ($rose(sda_oe) && !scl_oe |-> $past(scl_in, 2))
    else $error("start while clock line low");
  a_start_order: assert property ($rose(sda_oe) && !scl_oe |-> !scl_oe [*8] ##[7:10] scl_oe)
    else $error("start not followed by clock low");
  a_low_half: assert property ($fell(scl_oe) |-> lo_cnt_q inside {[8'd16:8'd19]})
    else $error("clock low half wrong length");
  a_idle_quiet: assert property (!busy |-> !scl_oe && !sda_oe)
    else $error("lines held while idle");
  a_end_flag: assert property ($fell(busy) |-> ##[0:2] (xfer_done_irq || ack_mismatch_irq))
    else $error("sequence ended without flag");
  a_nack_nodone: assert property ($rose(ack_mismatch_irq) && !xfer_done_irq |-> !xfer_done_irq [*8])
    else $error("done raised after mismatch");
  a_done_hold: assert property (xfer_done_irq && !irq_clr_done |=> xfer_done_irq)
    else $error("done flag dropped");
  a_nack_hold: assert property (ack_mismatch_irq && !irq_clr_nack |=> ack_mismatch_irq)
    else $error("mismatch flag dropped");
  c_done: cover property ($rose(xfer_done_irq));
  c_nack: cover property ($rose(ack_mismatch_irq));
  c_end: cover property ($fell(busy));
endmodule
bind i2c_master_write_sequencer i2c_wr_checker CHK (.clk_sys(clk_sys), .arst_n(arst_n),
  .transfer_go(transfer_go), .irq_clr_done(irq_clr_done), .irq_clr_nack(irq_clr_nack),
  .xfer_done_irq(xfer_done_irq), .ack_mismatch_irq(ack_mismatch_irq), .busy(busy),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// ==== i2c_wr_defines.svh ====
// Constants for the I2C master write sequencer
`ifndef I2C_WR_DEFINES_SVH
`define I2C_WR_DEFINES_SVH

// ----------------------------------------------------------------
// Command entry layout
// ----------------------------------------------------------------
`define CMD_W 14
`define CMD_OPC_HI 13
`define CMD_OPC_LO 11
`define CMD_ACK_VAL 10
`define CMD_ACK_EXP 9
`define CMD_ACK_CHK 8
`define CMD_BNUM_HI 7
`define CMD_BNUM_LO 0
`define OPC_RESTART 3'h0
`define OPC_WRITE 3'h1
`define OPC_STOP 3'h2

// ----------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------
`define RAM_DEPTH 16
`define RAM_AW 4
`define FIFO_DEPTH 8
`define BYTE_W 8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define SCL_HALF_NS 80
`define SCL_HALF_CYC ((`SCL_HALF_NS * `CLK_MHZ) / 1000)
`define SCL_QTR_CYC (`SCL_HALF_CYC / 2)

`endif

// ==== i2c_wr_pkg.sv ====
// Types for the I2C master write sequencer
package i2c_wr_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_WAIT_SCL = 4'b0001,
    ST_CMD = 4'b0010,
    ST_RS_LO = 4'b0011,
    ST_RS_HI = 4'b0100,
    ST_RS_SDA = 4'b0101,
    ST_LOAD = 4'b0110,
    ST_BIT_LO = 4'b0111,
    ST_BIT_HI = 4'b1000,
    ST_ACK_LO = 4'b1001,
    ST_ACK_HI = 4'b1010,
    ST_SP_LO = 4'b1011,
    ST_SP_HI = 4'b1100,
    ST_SP_END = 4'b1101
  } seq_state_t;

endpackage

// ==== tb.sv ====
// Bench: sequencer against a slave model, with receive RAM read-back
`timescale 1ns/100ps
`include "i2c_wr_defines.svh"
module tb;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic master_select = 1'b0;
  logic nonfifo_en = 1'b0;
  logic config_sync_strobe = 1'b0;
  logic transfer_go = 1'b0;
  logic [`CMD_W-1:0] c0 = '0, c1 = '0, c2 = '0;
  logic tx_wr_en = 1'b0;
  logic [`RAM_AW-1:0] tx_wr_addr = '0;
  logic [`BYTE_W-1:0] tx_wr_data = '0;
  logic irq_clr_done = 1'b0;
  logic irq_clr_nack = 1'b0;
  logic [4:0] nack_at = 5'h1f;
  logic xfer_done_irq, ack_mismatch_irq, busy, scl_out, scl_oe, sda_out, sda_oe;
  logic sda_pull, rx_stb;
  logic [7:0] rx_byte, rx_rd_data;
  logic [`RAM_AW-1:0] rx_rd_addr = '0;
  wire logic scl_w = ~scl_oe;
  wire logic sda_w = ~(sda_oe | sda_pull);
  int bad_count = 0;
  int tests_run = 0;
  logic [7:0] exp_b[$];
  logic [1:0] exp_f[$];
  always #2.5 clk_sys = ~clk_sys;
  i2c_master_write_sequencer DUT (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(1'b1),
    .master_select(master_select), .nonfifo_en(nonfifo_en),
    .config_sync_strobe(config_sync_strobe), .transfer_go(transfer_go),
    .cmd_entry_0(c0), .cmd_entry_1(c1), .cmd_entry_2(c2), .tx_wr_en(tx_wr_en),
    .tx_wr_addr(tx_wr_addr), .tx_wr_data(tx_wr_data), .rx_rd_addr(rx_rd_addr),
    .rx_rd_data(rx_rd_data),
    .irq_clr_done(irq_clr_done), .irq_clr_nack(irq_clr_nack), .xfer_done_irq(xfer_done_irq),
    .ack_mismatch_irq(ack_mismatch_irq), .busy(busy), .scl_in(scl_w), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_slave_model SLV (.scl(scl_w), .sda(sda_w), .nack_at(nack_at), .sda_pull(sda_pull),
    .rx_stb(rx_stb), .rx_byte(rx_byte));
  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmp_byte(logic [7:0] got, logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_flags(logic [1:0] got, logic [1:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t flags %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (bad_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One sequence: restart, write of all bytes (up to the refused byte when checked), stop
  task automatic run(logic [7:0] b[$], logic chk, logic nf, int na);
    int n;
    int sent;
    logic halt;
    n = b.size();
    halt = chk && (na < n);
    sent = halt ? na + 1 : n;
    nack_at = 5'(na);
    nonfifo_en = nf;
    master_select = 1'b1;
    c0 = {`OPC_RESTART, 11'h000};
    c1 = {`OPC_WRITE, 2'b00, chk, 8'(n)};
    c2 = {`OPC_STOP, 11'h000};
    config_sync_strobe = 1'b1;
    tick(1);
    config_sync_strobe = 1'b0;
    for (int i = 0; i < n; i++) begin
      tx_wr_en = 1'b1;
      tx_wr_addr = 4'(i);
      tx_wr_data = b[i];
      if (!halt || i <= na) exp_b.push_back(b[i]);
      tick(1);
    end
    tx_wr_en = 1'b0;
    exp_f.push_back(halt ? 2'b01 : 2'b10);
    transfer_go = 1'b1;
    tick(1);
    transfer_go = 1'b0;
    for (int k = 0; k < 20000 && busy !== 1'b0; k++) tick(1);
    if (busy !== 1'b0) begin
      bad_count++;
      $display("BAD %0t sequence did not end", $time);
    end
    tick(40);
    irq_clr_done = 1'b1;
    irq_clr_nack = 1'b1;
    tick(1);
    irq_clr_done = 1'b0;
    irq_clr_nack = 1'b0;
    for (int i = 0; i < sent; i++) begin
      rx_rd_addr = 4'(i);
      tick(1);
      cmp_byte(rx_rd_data, b[i]);
    end
    tick(2);
  endtask
  always @(posedge rx_stb) cmp_byte(rx_byte, exp_b.size() > 0 ? exp_b.pop_front() : 8'hxx);
  always @(negedge busy) begin
    if (arst_n === 1'b1) begin
      tick(3);
      cmp_flags({xfer_done_irq, ack_mismatch_irq}, exp_f[0]);
      tick(20);
      cmp_flags({xfer_done_irq, ack_mismatch_irq}, exp_f.pop_front());
    end
  end
  initial begin
    #300000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    logic [7:0] q[$];
    void'($urandom(32'hf71b));
    tick(8);
    arst_n = 1'b1;
    tick(2);
    cmp_flags({busy, scl_oe | sda_oe}, 2'b00);
    cmp_flags({xfer_done_irq, ack_mismatch_irq}, 2'b00);
    // Go with master mode not latched must be ignored
    config_sync_strobe = 1'b1;
    tick(1);
    config_sync_strobe = 1'b0;
    tick(1);
    transfer_go = 1'b1;
    tick(1);
    transfer_go = 1'b0;
    tick(4);
    cmp_flags({busy, scl_oe | sda_oe}, 2'b00);
    repeat (2) begin
      q = {8'hb4};
      repeat (9) q.push_back(8'($urandom));
      run(q, 1'b1, 1'b0, 31);
    end
    q = {8'hf4, 8'hc5, 8'($urandom), 8'($urandom)};
    run(q, 1'b1, 1'b1, 31);
    q = {8'hb4, 8'h20, 8'h5e, 8'ha7};
    run(q, 1'b0, 1'b1, 2);
    q = {8'hb4, 8'h11, 8'h22, 8'h33};
    run(q, 1'b1, 1'b1, 1);
    run(q, 1'b1, 1'b1, 31);
    cmp_byte(8'(exp_b.size()), 8'h00);
    tally_and_finish();
  end
endmodule

// ==== tx_byte_fifo.sv ====
// Byte FIFO between transmit RAM fetch and the bit shifter
`timescale 1ns/100ps
module tx_byte_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic [W-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (s_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (s_q.cnt != '0);
  assign out_data = mem[s_q.rp];
  assign push = in_valid && in_ready && !flush;
  assign pop = out_valid && out_ready && !flush;

  always_comb begin
    s_d = s_q;
    if (flush) begin
      s_d = '0;
    end else begin
      if (push) begin
        s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
      end
      if (pop) begin
        s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
      end
      s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clk_en && push) begin
      mem[s_q.wp] <= in_data;
    end
  end

endmodule
